// [shared/drs_defines.vh]
// Constants for the four-channel DMA request-select and transfer engine.
// Assumes a byte-addressed Avalon-MM slave with 32-bit data words.
`ifndef DRS_DEFINES_VH
`define DRS_DEFINES_VH

// Per-channel register offsets inside a 16-byte channel slot
`define DRS_OFS_SRC 4'h0
`define DRS_OFS_DST 4'h4
`define DRS_OFS_CNT 4'h8
`define DRS_OFS_CTRL 4'hc
// Global registers
`define DRS_OFS_OPER 7'h40
`define DRS_OFS_STAT 7'h44

// Control register fields
`define DRS_CTRL_EN 0
`define DRS_CTRL_TE 1
`define DRS_CTRL_RS_LO 2
`define DRS_CTRL_RS_HI 6
`define DRS_CTRL_BURST 7
`define DRS_CTRL_IND 8
`define DRS_CTRL_SZ_LO 9
`define DRS_CTRL_SZ_HI 10
`define DRS_CTRL_INCS 11
`define DRS_CTRL_INCD 12

// Operation register fields
`define DRS_OPER_ME 0
`define DRS_OPER_NMI 1
`define DRS_OPER_AE 2

// Request select codes
`define DRS_RS_AUTO 5'h00
`define DRS_RS_TMR_FIRST 5'h11
`define DRS_RS_TMR_LAST 5'h1c
`define DRS_TMR_REQS 12

// Transfer sizes
`define DRS_SZ_BYTE 2'h0
`define DRS_SZ_HALF 2'h1
`define DRS_SZ_WORD 2'h2

`define DRS_CNT_W 24
`define DRS_INDIRECT_CH 2'h3

`endif

// [design/drs_dma_core.v]
// Four-channel DMA engine: timer request select, fixed priority,
// direct and indirect dual-address transfers, Avalon-MM registers.
// Assumes requests, bus grant and memory ready share ref_clk.
`include "drs_defines.vh"
`default_nettype none

module drs_dma_core (
  // Clock and reset
  input wire ref_clk,
  input wire rstn,
  // Avalon-MM register slave
  input wire [6:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  // Timer triggers: captures t0 A-D, compares t6 A-D, t7 A-D
  input wire [11:0] timerReq,
  // Abort events
  input wire nmiEvent,
  input wire addrErrEvent,
  // System bus master
  output reg busReq,
  input wire busGrant,
  input wire busNarrow,
  output reg [31:0] memAddr,
  output reg memRead,
  output reg memWrite,
  output reg [31:0] memWdata,
  input wire [31:0] memRdata,
  input wire memReady
);

  localparam S_IDLE = 6'b000001;
  localparam S_REQ = 6'b000010;
  localparam S_PTR = 6'b000100;
  localparam S_NOP = 6'b001000;
  localparam S_RD = 6'b010000;
  localparam S_WR = 6'b100000;

  ////////////////////////////////////////////////////////////////////////
  // Shared state
  reg [5:0] state_r;
  reg [1:0] curCh_r;
  reg half_r;
  reg [31:0] ptr_r;
  reg [31:0] buf_r;
  reg masterEn_r;
  reg nmiFlag_r;
  reg aeFlag_r;
  reg [31:0] rdMux;
  wire busWr = avs_write && !avs_waitrequest;
  wire unitDone;
  wire [127:0] srcV;
  wire [127:0] dstV;
  wire [4*`DRS_CNT_W-1:0] cntV;
  wire [127:0] ctrlV;
  wire [3:0] chOk;
  wire [3:0] chReady;
  wire [3:0] chBurst;
  wire [3:0] chInd;
  wire [7:0] chSize;
  wire [3:0] chLast;

  ////////////////////////////////////////////////////////////////////////
  // Per-channel registers, trigger decode and pending requests
  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : gCh
      // Channel number at register width, so compares stay two bits
      localparam [1:0] CH = i;
      reg [31:0] src_r;
      reg [31:0] dst_r;
      reg [`DRS_CNT_W-1:0] cnt_r;
      reg en_r;
      reg te_r;
      reg [4:0] rs_r;
      reg burst_r;
      reg ind_r;
      reg [1:0] size_r;
      reg incS_r;
      reg incD_r;
      reg pend_r;
      wire hit = busWr && !avs_address[6] &&
        avs_address[5:4] == CH;
      wire [4:0] tIdx = rs_r - `DRS_RS_TMR_FIRST;
      wire inTmr = rs_r >= `DRS_RS_TMR_FIRST &&
        rs_r <= `DRS_RS_TMR_LAST;
      wire trig = inTmr && timerReq[tIdx[3:0]];
      wire here = unitDone && curCh_r == CH;
      wire [31:0] step = (ind_r && i == 3) ? 32'h4 :
        {29'h0, size_r == `DRS_SZ_WORD, size_r == `DRS_SZ_HALF,
        size_r == `DRS_SZ_BYTE};
      wire [31:0] dStep = {29'h0, size_r == `DRS_SZ_WORD,
        size_r == `DRS_SZ_HALF, size_r == `DRS_SZ_BYTE};

      // Software writes, engine address steps and count
      always @(posedge ref_clk) begin
        if (!rstn) begin
          src_r <= 32'h0;
          dst_r <= 32'h0;
          cnt_r <= {`DRS_CNT_W{1'b0}};
          en_r <= 1'b0;
          te_r <= 1'b0;
          rs_r <= 5'h00;
          burst_r <= 1'b0;
          ind_r <= 1'b0;
          size_r <= 2'h0;
          incS_r <= 1'b0;
          incD_r <= 1'b0;
          pend_r <= 1'b0;
        end else begin
          if (hit && avs_address[3:0] == `DRS_OFS_SRC)
            src_r <= avs_writedata;
          else if (here && incS_r)
            src_r <= src_r + step;
          if (hit && avs_address[3:0] == `DRS_OFS_DST)
            dst_r <= avs_writedata;
          else if (here && incD_r)
            dst_r <= dst_r + dStep;
          if (hit && avs_address[3:0] == `DRS_OFS_CNT)
            cnt_r <= avs_writedata[`DRS_CNT_W-1:0];
          else if (here)
            cnt_r <= cnt_r - 1'b1;
          if (hit && avs_address[3:0] == `DRS_OFS_CTRL) begin
            en_r <= avs_writedata[`DRS_CTRL_EN];
            rs_r <= avs_writedata[`DRS_CTRL_RS_HI:`DRS_CTRL_RS_LO];
            burst_r <= avs_writedata[`DRS_CTRL_BURST];
            ind_r <= avs_writedata[`DRS_CTRL_IND] && i == 3;
            size_r <= avs_writedata[`DRS_CTRL_SZ_HI:`DRS_CTRL_SZ_LO];
            incS_r <= avs_writedata[`DRS_CTRL_INCS];
            incD_r <= avs_writedata[`DRS_CTRL_INCD];
          end
          // End flag: a count reaching zero beats a clearing write
          te_r <= (here && cnt_r == 1) | (te_r & !(hit &&
            avs_address[3:0] == `DRS_OFS_CTRL &&
            !avs_writedata[`DRS_CTRL_TE]));
          // A trigger in the finishing cycle stays pending
          pend_r <= trig | (pend_r & !here);
        end
      end

      assign srcV[i*32 +: 32] = src_r;
      assign dstV[i*32 +: 32] = dst_r;
      assign cntV[i*`DRS_CNT_W +: `DRS_CNT_W] = cnt_r;
      assign ctrlV[i*32 +: 32] = {19'h0, incD_r, incS_r, size_r,
        ind_r, burst_r, rs_r, te_r, en_r};
      assign chOk[i] = en_r && masterEn_r && !te_r && !nmiFlag_r &&
        !aeFlag_r && cnt_r != 0;
      assign chReady[i] = chOk[i] &&
        (rs_r == `DRS_RS_AUTO || pend_r);
      assign chBurst[i] = burst_r;
      assign chInd[i] = ind_r;
      assign chSize[i*2 +: 2] = size_r;
      assign chLast[i] = cnt_r == 1;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Fixed priority: lowest numbered ready channel wins
  reg [1:0] winner;
  integer k;
  always @* begin
    winner = 2'h3;
    for (k = 3; k >= 0; k = k - 1)
      if (chReady[k])
        winner = k[1:0];
  end
  wire anyReady = |chReady;

  ////////////////////////////////////////////////////////////////////////
  // Current channel view and access shaping
  wire [31:0] curSrc = srcV[curCh_r*32 +: 32];
  wire [31:0] curDst = dstV[curCh_r*32 +: 32];
  wire curInd = chInd[curCh_r];
  wire curWord = chSize[curCh_r*2 +: 2] == `DRS_SZ_WORD;
  // Pointer is always a word; data only when the size says so
  wire twoHalves = busNarrow &&
    (state_r == S_PTR || curWord);
  wire strobe = memRead || memWrite;
  wire accDone = strobe && memReady;
  wire lastHalf = !twoHalves || half_r;
  assign unitDone = state_r == S_WR && accDone && lastHalf;
  wire [31:0] halfOfs = {30'h0, half_r, 1'b0};
  reg [31:0] accAddr;

  // Address for the access about to start
  always @* begin
    case (state_r)
      S_PTR: accAddr = curSrc + halfOfs;
      S_RD: accAddr = (curInd ? ptr_r : curSrc) + halfOfs;
      S_WR: accAddr = curDst + halfOfs;
      default: accAddr = 32'h0;
    endcase
  end

  // Next unit after a finished one, same channel in burst
  wire keepBus = chBurst[curCh_r] && chOk[curCh_r] &&
    !chLast[curCh_r];

  ////////////////////////////////////////////////////////////////////////
  // Transfer engine; every unit is a read followed by a write
  always @(posedge ref_clk) begin
    if (!rstn) begin
      state_r <= S_IDLE;
      curCh_r <= 2'h0;
      half_r <= 1'b0;
      ptr_r <= 32'h0;
      buf_r <= 32'h0;
      busReq <= 1'b0;
      memAddr <= 32'h0;
      memRead <= 1'b0;
      memWrite <= 1'b0;
      memWdata <= 32'h0;
    end else begin
      case (state_r)
        S_IDLE: begin
          if (anyReady) begin
            busReq <= 1'b1;
            state_r <= S_REQ;
          end
        end
        S_REQ: begin
          // Winner taken at grant, so late higher requests count
          if (!anyReady) begin
            busReq <= 1'b0;
            state_r <= S_IDLE;
          end else if (busGrant) begin
            curCh_r <= winner;
            half_r <= 1'b0;
            state_r <= chInd[winner] ? S_PTR : S_RD;
          end
        end
        S_NOP: state_r <= S_RD;
        S_PTR, S_RD, S_WR: begin
          if (!strobe) begin
            memAddr <= accAddr;
            memRead <= state_r != S_WR;
            memWrite <= state_r == S_WR;
            // Narrow bus sends the high half first
            memWdata <= !twoHalves ? buf_r :
              (half_r ? {16'h0, buf_r[15:0]} :
              {16'h0, buf_r[31:16]});
          end else if (memReady) begin
            memRead <= 1'b0;
            memWrite <= 1'b0;
            if (state_r == S_PTR) begin
              if (!twoHalves)
                ptr_r <= memRdata;
              else if (!half_r)
                ptr_r[31:16] <= memRdata[15:0];
              else
                ptr_r[15:0] <= memRdata[15:0];
            end
            if (state_r == S_RD) begin
              if (!twoHalves)
                buf_r <= memRdata;
              else if (!half_r)
                buf_r[31:16] <= memRdata[15:0];
              else
                buf_r[15:0] <= memRdata[15:0];
            end
            if (!lastHalf)
              half_r <= 1'b1;
            else begin
              half_r <= 1'b0;
              case (state_r)
                S_PTR: state_r <= S_NOP;
                S_RD: state_r <= S_WR;
                default: begin
                  if (keepBus)
                    state_r <= curInd ? S_PTR : S_RD;
                  else begin
                    busReq <= 1'b0;
                    state_r <= S_IDLE;
                  end
                end
              endcase
            end
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Global enable and abort flags; events win over clearing writes
  wire operHit = busWr && avs_address == `DRS_OFS_OPER;
  always @(posedge ref_clk) begin
    if (!rstn) begin
      masterEn_r <= 1'b0;
      nmiFlag_r <= 1'b0;
      aeFlag_r <= 1'b0;
    end else begin
      if (operHit)
        masterEn_r <= avs_writedata[`DRS_OPER_ME];
      nmiFlag_r <= nmiEvent | (nmiFlag_r &
        !(operHit && !avs_writedata[`DRS_OPER_NMI]));
      aeFlag_r <= addrErrEvent | (aeFlag_r &
        !(operHit && !avs_writedata[`DRS_OPER_AE]));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data select; unmapped words read zero
  always @* begin
    rdMux = 32'h0;
    if (!avs_address[6]) begin
      case (avs_address[3:0])
        `DRS_OFS_SRC: rdMux = srcV[avs_address[5:4]*32 +: 32];
        `DRS_OFS_DST: rdMux = dstV[avs_address[5:4]*32 +: 32];
        `DRS_OFS_CNT: rdMux = {{(32-`DRS_CNT_W){1'b0}},
          cntV[avs_address[5:4]*`DRS_CNT_W +: `DRS_CNT_W]};
        `DRS_OFS_CTRL: rdMux = ctrlV[avs_address[5:4]*32 +: 32];
        default: rdMux = 32'h0;
      endcase
    end else if (avs_address == `DRS_OFS_OPER)
      rdMux = {29'h0, aeFlag_r, nmiFlag_r, masterEn_r};
    else if (avs_address == `DRS_OFS_STAT)
      rdMux = {23'h0, state_r, curCh_r, state_r != S_IDLE};
  end

  ////////////////////////////////////////////////////////////////////////
  // Avalon slave: one wait cycle, then a single ready cycle
  always @(posedge ref_clk) begin
    if (!rstn) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0;
    end else if ((avs_read || avs_write) && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
      avs_readdata <= rdMux;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

endmodule

`default_nettype wire

// [testbench/drs_mem_model.sv]
// Far side of the DMA core: bus arbiter plus a small memory.
// Assumes one clock with the core; narrow space puts data on [15:0].
`default_nettype none
module drs_mem_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Bus request side
  input wire logic busReq,
  output logic busGrant,
  input wire logic busNarrow,
  // Access side
  input wire logic memRead,
  input wire logic memWrite,
  input wire logic [31:0] memAddr,
  input wire logic [31:0] memWdata,
  output logic [31:0] memRdata,
  output logic memReady
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] mem [0:63];
  logic [31:0] logA [0:63];
  logic [31:0] w;
  logic [31:0] lastR;
  logic [1:0] wt;
  int nAcc;
  // Cycle stamps per access: first strobe cycle and ready cycle
  int cyc;
  int logS [0:63];
  int logT [0:63];
  ////////////////////////////////////////
  // Odd accesses stall two cycles, even ones answer at once
  assign w = mem[memAddr[7:2]];
  assign memReady = (memRead | memWrite) && wt == (nAcc[0] ? 2'h2 : 2'h0);
  // Narrow space: even halfword is the high half
  assign memRdata = (memReady && memRead) ?
    (!busNarrow ? w : memAddr[1] ? {16'h0, w[15:0]} : {16'h0, w[31:16]})
    : ~lastR; // Released lines show ~lastR, which each completed write inverts
  // Plain memory stands behind any endpoint software picks
  always @(posedge ref_clk) begin
    busGrant <= busReq && rstn;
    wt <= ((memRead | memWrite) && !memReady) ? wt + 2'h1 : 2'h0;
    if (!rstn) begin
      nAcc <= 0;
      cyc <= 0;
    end else begin
      cyc <= cyc + 1;
      if ((memRead | memWrite) && wt == 2'h0) begin
        logS[nAcc[5:0]] <= cyc;
      end
      if (memReady) begin
        logT[nAcc[5:0]] <= cyc;
        logA[nAcc[5:0]] <= {memWrite, memAddr[30:0]};
        nAcc <= nAcc + 1;
        lastR <= memRdata;
        if (memWrite && !busNarrow) begin
          mem[memAddr[7:2]] <= memWdata;
        end else if (memWrite && memAddr[1]) begin
          mem[memAddr[7:2]][15:0] <= memWdata[15:0];
        end else if (memWrite) begin
          mem[memAddr[7:2]][31:16] <= memWdata[15:0];
        end
      end
    end
  end
endmodule
`default_nettype wire

// [testbench/drs_dma_monitor.sv]
// Checker for the DMA core bus and register handshakes.
// Bound to drs_dma_core; sees only its ports.
`default_nettype none
module drs_dma_monitor (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Register slave
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  // System bus
  input wire logic busReq,
  input wire logic busGrant,
  input wire logic busNarrow,
  input wire logic memRead,
  input wire logic memWrite,
  input wire logic memReady,
  input wire logic [31:0] memAddr,
  input wire logic [31:0] memWdata,
  input wire logic [31:0] memRdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] lastRd;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////
  // Last word read: a wide direct write must carry it
  always_ff @(posedge ref_clk) begin
    if (memRead && memReady) begin
      lastRd <= memRdata;
    end
  end
  AST_RW_EXCL: assert property (!(memRead && memWrite))
    else $error("read and write strobes together");
  AST_RD_HOLD: assert property (memRead && !memReady |=>
    memRead && $stable(memAddr)) else $error("read dropped early");
  AST_WR_HOLD: assert property (memWrite && !memReady |=>
    memWrite && $stable(memAddr) && $stable(memWdata))
    else $error("write changed early");
  AST_DROP: assert property ((memRead || memWrite) && memReady |=>
    !memRead && !memWrite) else $error("no idle cycle after access");
  AST_GRANT: assert property ((memRead || memWrite) |->
    busReq && busGrant) else $error("access without the bus");
  AST_WDATA: assert property ($rose(memWrite) && !busNarrow |->
    memWdata == lastRd) else $error("write data not buffered word");
  AST_AVS_ANSWER: assert property ((avs_read || avs_write) &&
    avs_waitrequest |=> !avs_waitrequest) else $error("slave slow");
  AST_AVS_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low twice");
  cover property (memWrite && memReady && !busNarrow);
  cover property (memRead && memReady && busNarrow);
  cover property (!avs_waitrequest && avs_read);
endmodule
bind drs_dma_core drs_dma_monitor i_mon (.ref_clk, .rstn, .avs_read,
  .avs_write, .avs_waitrequest, .busReq, .busGrant, .busNarrow,
  .memRead, .memWrite, .memReady, .memAddr, .memWdata, .memRdata);
`default_nettype wire

// [testbench/tb_dma_request_select_dual_address.sv]
// Self-checking bench for the DMA request-select and transfer core.
// Assumes drs_mem_model as arbiter and memory, checker bound.
`include "drs_defines.vh"
`default_nettype none
module tb_dma_request_select_dual_address;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [6:0] avs_address = 7'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [11:0] timerReq = 12'h0;
  logic nmiEvent = 1'b0;
  logic addrErrEvent = 1'b0;
  logic busNarrow = 1'b0;
  wire [31:0] avs_readdata, memAddr, memWdata, memRdata;
  wire avs_waitrequest, busReq, busGrant, memRead, memWrite, memReady;
  int miscompares = 0;
  int total_checks = 0;
  drs_dma_core i_dut (.ref_clk, .rstn, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
    .timerReq, .nmiEvent, .addrErrEvent, .busReq, .busGrant,
    .busNarrow, .memAddr, .memRead, .memWrite, .memWdata, .memRdata,
    .memReady);
  drs_mem_model i_mem (.ref_clk, .rstn, .busReq, .busGrant, .busNarrow,
    .memRead, .memWrite, .memAddr, .memWdata, .memRdata, .memReady);
  initial forever #25 ref_clk = ~ref_clk;
  ////////////////////////////////////////
  task conclude;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One Avalon access; held until waitrequest is sampled low
  task avAcc(input logic w, input logic [6:0] a, input logic [31:0] d,
             output logic [31:0] q);
    int n;
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !w;
    avs_write <= w;
    n = 0;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0 && n < 50) begin
      @(posedge ref_clk);
      n++;
    end
    q = avs_readdata;
    if (n >= 50) begin
      chk("waitrequest", 32'h0, 32'h1);
      conclude;
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge ref_clk); // Gap keeps one assignment per time step
  endtask
  task wr(input logic [6:0] a, input logic [31:0] d);
    logic [31:0] q;
    avAcc(1'b1, a, d, q);
  endtask
  // Bounded wait for a number of completed bus accesses
  task waitN(input int t);
    int k;
    for (k = 0; k < 500 && i_mem.nAcc < t; k++) @(posedge ref_clk);
    if (i_mem.nAcc < t) begin
      chk("access count", t, i_mem.nAcc);
      conclude;
    end
  endtask
  // Word transfer, both addresses incrementing, channel enabled
  function logic [31:0] ctl(input logic [4:0] rs, input logic b, ind);
    ctl = {19'h0, 2'h3, `DRS_SZ_WORD, ind, b, rs, 2'h1};
  endfunction
  ////////////////////////////////////////
  task tRegs;
    logic [31:0] q;
    wr(7'h04, 32'h12345678);
    avAcc(1'b0, 7'h04, 32'h0, q);
    chk("dest register", 32'h12345678, q);
    avAcc(1'b0, 7'h50, 32'h0, q);
    chk("unmapped read", 32'h0, q);
    wr(7'h0c, 32'h100);
    avAcc(1'b0, 7'h0c, 32'h0, q);
    chk("indirect on ch0", 32'h0, {31'h0, q[8]});
    $display("test regs done");
  endtask
  // Every timer code fires on its own trigger and not on the next one
  task tTimer;
    int k;
    int base;
    logic [31:0] q;
    wr(7'h40, 32'h1);
    for (k = 0; k < 12; k++) begin
      base = i_mem.nAcc;
      wr(7'h10, 32'h0);
      wr(7'h14, 32'h24);
      wr(7'h18, 32'h1);
      wr(7'h1c, ctl(`DRS_RS_TMR_FIRST + k, 1'b0, 1'b0));
      timerReq <= 12'h1 << ((k + 1) % 12);
      @(posedge ref_clk);
      timerReq <= 12'h0;
      repeat (15) @(posedge ref_clk);
      chk("foreign trigger", base, i_mem.nAcc);
      timerReq <= 12'h1 << k;
      @(posedge ref_clk);
      timerReq <= 12'h0;
      waitN(base + 2);
      chk("read address", 32'h0, i_mem.logA[base]);
      chk("write address", 32'h80000024, i_mem.logA[base + 1]);
      repeat (3) @(posedge ref_clk);
      chk("bus request", 32'h0, {31'h0, busReq});
      avAcc(1'b0, 7'h18, 32'h0, q);
      chk("count", 32'h0, q);
      avAcc(1'b0, 7'h1c, 32'h0, q);
      chk("end flag", 32'h1, {31'h0, q[1]});
    end
    chk("copied word", 32'h5a5a0f0f, i_mem.mem[9]);
    $display("test timer done");
  endtask
  // Four auto channels at once; NMI flag, then address-error flag, holds them back first
  task tPrio;
    int k;
    int base;
    logic [31:0] q;
    logic [7:0] ex [5];
    ex = '{8'h80, 8'h84, 8'h90, 8'ha0, 8'hb0};
    wr(7'h40, 32'h0);
    for (k = 0; k < 4; k++) begin
      wr(7'(k * 16), 32'h0);
      wr(7'(k * 16 + 4), 32'h80 + k * 16);
      wr(7'(k * 16 + 8), k == 0 ? 32'h2 : 32'h1);
      wr(7'(k * 16 + 12), ctl(`DRS_RS_AUTO, k == 0, 1'b0));
    end
    base = i_mem.nAcc;
    // k = 1: abort event, k = 2: address-error event, each alone
    for (k = 1; k < 3; k++) begin
      nmiEvent <= k == 1;
      addrErrEvent <= k == 2;
      @(posedge ref_clk);
      nmiEvent <= 1'b0;
      addrErrEvent <= 1'b0;
      wr(7'h40, 32'h1 | (32'h1 << k));
      repeat (15) @(posedge ref_clk);
      chk("blocked accesses", base, i_mem.nAcc);
      avAcc(1'b0, 7'h40, 32'h0, q);
      chk("abort flag", 32'h1 << k, q & 32'h6);
      wr(7'h40, 32'h0);
    end
    wr(7'h40, 32'h1);
    waitN(base + 10);
    for (k = 0; k < 5; k++) begin
      q = i_mem.logA[base + 1 + 2 * k];
      chk("write order", {24'h800000, ex[k]}, q);
    end
    $display("test priority done");
  endtask
  // Channel 3 indirect, word data over the narrow bus
  task tIndirect;
    int k;
    int base;
    logic [31:0] ex [6];
    ex = '{32'h40, 32'h42, 32'hc0, 32'hc2, 32'h800000d0, 32'h800000d2};
    busNarrow <= 1'b1;
    base = i_mem.nAcc;
    wr(7'h30, 32'h40);
    wr(7'h34, 32'hd0);
    wr(7'h38, 32'h1);
    wr(7'h3c, ctl(`DRS_RS_AUTO, 1'b0, 1'b1));
    waitN(base + 6);
    repeat (10) @(posedge ref_clk);
    chk("access total", base + 6, i_mem.nAcc);
    for (k = 0; k < 6; k++) begin
      chk("indirect access", ex[k], i_mem.logA[base + k]);
    end
    chk("indirect data", 32'hdeadbeef, i_mem.mem[52]);
    chk("nop gap", 32'h3, i_mem.logS[base + 2] - i_mem.logT[base + 1]);
    chk("rd wr gap", 32'h2, i_mem.logS[base + 4] - i_mem.logT[base + 3]);
    $display("test indirect done");
  endtask
  ////////////////////////////////////////
  initial begin
    i_mem.mem[0] = 32'h5a5a0f0f;
    i_mem.mem[16] = 32'h000000c0;
    i_mem.mem[48] = 32'hdeadbeef;
    repeat (10) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    tRegs;
    tTimer;
    tPrio;
    tIndirect;
    conclude;
  end
endmodule
`default_nettype wire
